// ### hdl/cup_bank.sv
// serial-bus slave and register bank of the bus-input charging core
//
// Overview of operation
// - timer kick bit pulses, then self-clears
// - status top bit reads host-mode pin level
// - status-pin enable gates charge status pin
// - charge state reads ready/charging/done/fault
// - charge-mode fault codes reported in order
// - boost-mode fault codes reported, last unused
// - input limit 100/500/800 mA or none
// - weak battery threshold 3.4 V plus weights
// - end-cut enable allows low-current termination
// - charger-off bit disables charging
// - high-impedance bit puts input in hi-z
// - operation select boost, boost status bit
// - regulation voltage 3.5 V plus 20 mV
// - host pin enable and active level
// - identity register read-only maker/part/revision
// - core reset bit, write-only, reads zero
// - fast charge code weights, lowest unweighted
// - termination code weights, lowest defaults one
// - bus charging current ceiling is 7, full scale, so never clamps
// - bus, wall and power-management flags read
// - low-current bit overrides fast charge code
// - special supply voltage 4.2 V plus weights
// - answer only at slave address 1101011
`timescale 1ns/1ps
`include "cup_regs.svh"

module cup_bank #(
  parameter logic [6:0] SLAVE_ADDR = `CUP_SLAVE_ADDR,
  parameter logic [2:0] MAKER_CODE = 3'h3,   // arbitrary value
  parameter logic [1:0] PART_CODE  = 2'h1,   // arbitrary value
  parameter logic [2:0] REV_CODE   = 3'h1    // arbitrary value
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_n_o,
  input  wire logic                host_mode_request_pin_i,
  input  cup_pkg::cup_status_t     status_i,
  input  wire logic [2:0]          safety_fast_limit_i,
  output cup_pkg::cup_ctrl_t       ctrl_o,
  output logic                     safety_timer_kick_o,
  output logic                     core_reset_o,
  output logic                     host_mode_active_o,
  output logic                     stat_o,
  output logic                     stat_oe_n_o,
  output logic [2:0]               eff_fast_weight_o,
  output logic                     eff_low_current_o
);
  import cup_pkg::*;

  initial begin
    if (SLAVE_ADDR == 7'h00) begin
      $error("slave address zero is the general call");
    end
  end

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  // the bus has no glitch filter, so a noisy scl will miscount bits
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic host_m, host_s;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      scl_d  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      sda_d  <= 1'b1;
      host_m <= 1'b0;
      host_s <= 1'b0;
    end else begin
      scl_m  <= scl_i;
      scl_s  <= scl_m;
      scl_d  <= scl_s;
      sda_m  <= sda_i;
      sda_s  <= sda_m;
      sda_d  <= sda_s;
      host_m <= host_mode_request_pin_i;
      host_s <= host_m;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  cup_ctrl_t  ctrl;
  logic       stat_en;
  logic       wr_stb;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;

  function automatic cup_ctrl_t ctrl_default();
    cup_ctrl_t c;
    {c.input_limit, c.weak_battery_threshold, c.end_cut_enable,
     c.charger_off, c.input_high_impedance,
     c.operation_select} = `CUP_RST_CTL;
    {c.regulation_voltage_code, c.host_pin_polarity,
     c.host_pin_enable} = `CUP_RST_VREG;
    {c.fast_current_code, c.end_current_code} = `CUP_RST_CUR;
    c.low_current_override = `CUP_RST_LOWC;
    c.special_supply_voltage_code = `CUP_RST_SPECIAL_SUPPLY_VOLTAGE_CODE;
    return c;
  endfunction

  localparam cup_ctrl_t CTRL_RST = ctrl_default();

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl                <= CTRL_RST;
      stat_en             <= `CUP_RST_STAT_EN;
      safety_timer_kick_o <= 1'b0;
      core_reset_o        <= 1'b0;
    end else begin
      safety_timer_kick_o <= 1'b0;
      core_reset_o        <= 1'b0;
      if (core_reset_o) begin
        ctrl    <= ctrl_default();
        stat_en <= `CUP_RST_STAT_EN;
      end else if (wr_stb) begin
        unique case (wr_ptr)
          `CUP_REG_STAT: begin
            safety_timer_kick_o <= wr_data[`CUP_KICK_BIT];
            stat_en             <= wr_data[`CUP_STATEN_BIT];
          end
          `CUP_REG_CTL: begin
            {ctrl.input_limit, ctrl.weak_battery_threshold,
             ctrl.end_cut_enable, ctrl.charger_off,
             ctrl.input_high_impedance,
             ctrl.operation_select} <= wr_data;
          end
          `CUP_REG_VREG: begin
            {ctrl.regulation_voltage_code, ctrl.host_pin_polarity,
             ctrl.host_pin_enable} <= wr_data;
          end
          `CUP_REG_CUR: begin
            core_reset_o <= wr_data[`CUP_CORE_RST_BIT];
            {ctrl.fast_current_code, ctrl.end_current_code} <=
              wr_data[`CUP_CORE_RST_BIT-1:0];
          end
          `CUP_REG_SPEC: begin
            ctrl.low_current_override <= wr_data[`CUP_LOWC_BIT];
            ctrl.special_supply_voltage_code <=
              wr_data[`CUP_SPECIAL_SUPPLY_VOLTAGE_CODE_MSB:0];
          end
          default: begin
            // identity and unmapped offsets ignore writes
          end
        endcase
      end
    end
  end

  assign ctrl_o = ctrl;

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------
  logic [7:0] ptr;
  logic [7:0] rd_byte;

  always_comb begin
    unique case (ptr)
      `CUP_REG_STAT: rd_byte = {host_s, stat_en, status_i.charge_state,
                                status_i.boost_active,
                                status_i.fault};
      `CUP_REG_CTL:  rd_byte = {ctrl.input_limit,
                                ctrl.weak_battery_threshold,
                                ctrl.end_cut_enable, ctrl.charger_off,
                                ctrl.input_high_impedance,
                                ctrl.operation_select};
      `CUP_REG_VREG: rd_byte = {ctrl.regulation_voltage_code,
                                ctrl.host_pin_polarity,
                                ctrl.host_pin_enable};
      `CUP_REG_ID:   rd_byte = {MAKER_CODE, PART_CODE, REV_CODE};
      `CUP_REG_CUR:  rd_byte = {1'b0, ctrl.fast_current_code,
                                ctrl.end_current_code};
      `CUP_REG_SPEC: rd_byte = {1'b0, status_i.bus_power_present,
                                ctrl.low_current_override,
                                status_i.power_management_active,
                                status_i.wall_input_present,
                                ctrl.special_supply_voltage_code};
      default:       rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // serial-bus slave
  // ------------------------------------------------------------
  cup_i2c_state_t st;
  logic [3:0]     bitcnt;
  logic [7:0]     shift;
  logic [7:0]     tx;
  logic           rw;
  logic           nack;
  logic           load_tx;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st         <= ST_IDLE;
      bitcnt     <= 4'h0;
      shift      <= 8'h00;
      tx         <= 8'h00;
      rw         <= 1'b0;
      nack       <= 1'b1;
      ptr        <= 8'h00;
      sda_oe_n_o <= 1'b1;
      wr_stb     <= 1'b0;
      wr_ptr     <= 8'h00;
      wr_data    <= 8'h00;
      load_tx    <= 1'b0;
    end else begin
      wr_stb  <= 1'b0;
      load_tx <= 1'b0;
      if (start_c) begin
        st         <= ST_ADDR;
        bitcnt     <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_c) begin
        st         <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (scl_rise) begin
        unique case (st)
          ST_ADDR, ST_PTR, ST_WR: begin
            shift  <= {shift[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RD:   bitcnt <= bitcnt + 4'h1;
          ST_RACK: nack <= sda_s;
          ST_IDLE, ST_AACK, ST_PACK, ST_WACK: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (st)
          ST_ADDR: begin
            if (bitcnt == `CUP_BYTE_BITS) begin
              if (shift[7:1] == SLAVE_ADDR) begin
                st         <= ST_AACK;
                rw         <= shift[0];
                sda_oe_n_o <= 1'b0;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bitcnt <= 4'h0;
            if (rw) begin
              st         <= ST_RD;
              tx         <= rd_byte;
              sda_oe_n_o <= rd_byte[7];
              load_tx    <= 1'b1;
            end else begin
              st         <= ST_PTR;
              sda_oe_n_o <= 1'b1;
            end
          end
          ST_PTR: begin
            if (bitcnt == `CUP_BYTE_BITS) begin
              ptr        <= shift;
              st         <= ST_PACK;
              sda_oe_n_o <= 1'b0;
            end
          end
          ST_PACK, ST_WACK: begin
            st         <= ST_WR;
            bitcnt     <= 4'h0;
            sda_oe_n_o <= 1'b1;
          end
          ST_WR: begin
            if (bitcnt == `CUP_BYTE_BITS) begin
              wr_stb     <= 1'b1;
              wr_ptr     <= ptr;
              wr_data    <= shift;
              ptr        <= ptr + 8'h01;
              st         <= ST_WACK;
              sda_oe_n_o <= 1'b0;
            end
          end
          ST_RD: begin
            if (bitcnt == `CUP_BYTE_BITS) begin
              st         <= ST_RACK;
              ptr        <= ptr + 8'h01;
              sda_oe_n_o <= 1'b1;
            end else begin
              tx         <= {tx[6:0], 1'b0};
              sda_oe_n_o <= tx[6];
            end
          end
          ST_RACK: begin
            bitcnt <= 4'h0;
            if (!nack) begin
              st         <= ST_RD;
              tx         <= rd_byte;
              sda_oe_n_o <= rd_byte[7];
              load_tx    <= 1'b1;
            end else begin
              st <= ST_IDLE;
            end
          end
          ST_IDLE: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pins and derived controls
  // ------------------------------------------------------------
  // effective code is one cycle behind the register; the analog loop
  // cannot follow faster than that anyway
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_o              <= 1'b0;
      stat_o             <= 1'b0;
      stat_oe_n_o        <= 1'b1;
      host_mode_active_o <= 1'b0;
      eff_fast_weight_o  <= 3'h0;
      eff_low_current_o  <= 1'b1;
    end else begin
      sda_o       <= 1'b0;
      stat_o      <= 1'b0;
      stat_oe_n_o <= !(stat_en &&
                       status_i.charge_state == CHG_CHARGING);
      host_mode_active_o <= ctrl.host_pin_enable &&
                            (host_s == ctrl.host_pin_polarity);
      eff_low_current_o  <= ctrl.low_current_override;
      if (ctrl.fast_current_code[3:1] > safety_fast_limit_i) begin
        eff_fast_weight_o <= safety_fast_limit_i;
      end else if (status_i.bus_power_present &&
                   ctrl.fast_current_code[3:1] > `CUP_BUS_CEIL) begin
        eff_fast_weight_o <= `CUP_BUS_CEIL;
      end else begin
        eff_fast_weight_o <= ctrl.fast_current_code[3:1];
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_kick_once;
    safety_timer_kick_o |=> !safety_timer_kick_o;
  endproperty
  a_kick_once: assert property (p_kick_once)
    else $error("timer kick held longer than one cycle");

  property p_kick_cause;
    (wr_stb && wr_ptr == `CUP_REG_STAT && wr_data[`CUP_KICK_BIT])
      |=> safety_timer_kick_o;
  endproperty
  a_kick_cause: assert property (p_kick_cause)
    else $error("timer kick write gave no pulse");

  property p_host_read;
    (load_tx && ptr == `CUP_REG_STAT) |-> tx[7] == $past(host_s);
  endproperty
  a_host_read: assert property (p_host_read)
    else $error("status top bit differs from host pin");

  property p_stat_gate;
    !stat_en |=> stat_oe_n_o;
  endproperty
  a_stat_gate: assert property (p_stat_gate)
    else $error("status pin driven while disabled");

  property p_stat_low;
    (stat_en && status_i.charge_state == CHG_CHARGING) |=> !stat_oe_n_o;
  endproperty
  a_stat_low: assert property (p_stat_low)
    else $error("status pin not pulled low while charging");

  property p_rst_reads_zero;
    (load_tx && ptr == `CUP_REG_CUR) |-> !tx[7];
  endproperty
  a_rst_reads_zero: assert property (p_rst_reads_zero)
    else $error("core reset bit read as one");

  property p_core_reset;
    core_reset_o |=> ctrl == ctrl_default() && !core_reset_o;
  endproperty
  a_core_reset: assert property (p_core_reset)
    else $error("core reset did not restore defaults");

  property p_ceiling;
    eff_fast_weight_o <= $past(safety_fast_limit_i) &&
      eff_fast_weight_o <= $past(ctrl.fast_current_code[3:1]) &&
      (eff_fast_weight_o == $past(safety_fast_limit_i) ||
       eff_fast_weight_o == $past(ctrl.fast_current_code[3:1]));
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("fast charge weight above safety limit");

  property p_low_override;
    ctrl.low_current_override |=> eff_low_current_o;
  endproperty
  a_low_override: assert property (p_low_override)
    else $error("low current override not applied");

  property p_addr_miss;
    (scl_fall && !start_c && !stop_c && st == ST_ADDR &&
     bitcnt == `CUP_BYTE_BITS && shift[7:1] != SLAVE_ADDR)
      |=> st == ST_IDLE && sda_oe_n_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("slave answered a foreign address");

  c_write: cover property (wr_stb && wr_ptr == `CUP_REG_CTL);
  c_read:  cover property (load_tx && ptr == `CUP_REG_STAT);
  c_kick:  cover property (safety_timer_kick_o);
  c_reset: cover property (core_reset_o);
endmodule

// ### hdl/cup_regs.svh
// register map constants of the bus-input charging core register bank
`ifndef CUP_REGS_SVH
`define CUP_REGS_SVH
`define CUP_SLAVE_ADDR   7'h6B
`define CUP_REG_STAT     8'h00
`define CUP_REG_CTL      8'h01
`define CUP_REG_VREG     8'h02
`define CUP_REG_ID       8'h03
`define CUP_REG_CUR      8'h04
`define CUP_REG_SPEC     8'h05
`define CUP_RST_STAT_EN  1'b1
`define CUP_RST_CTL      8'h30
`define CUP_RST_VREG     8'h0A
`define CUP_RST_CUR      7'h01
`define CUP_RST_LOWC     1'b1
`define CUP_RST_SPECIAL_SUPPLY_VOLTAGE_CODE    3'h4
`define CUP_KICK_BIT     7
`define CUP_STATEN_BIT   6
`define CUP_CORE_RST_BIT 7
`define CUP_LOWC_BIT     5
`define CUP_SPECIAL_SUPPLY_VOLTAGE_CODE_MSB    2
`define CUP_BYTE_BITS    4'h8
`define CUP_BUS_CEIL     3'h7
`endif

// ### hdl/cup_pkg.sv
// types shared by the charging core register bank
package cup_pkg;
  typedef enum logic [1:0] {
    CHG_READY, CHG_CHARGING, CHG_DONE, CHG_FAULT
  } cup_chg_state_t;
  typedef enum logic [2:0] {
    CF_NORMAL, CF_IN_OVP, CF_SLEEP, CF_BAD_ADAPTOR, CF_OUT_OVP,
    CF_THERMAL, CF_TIMER, CF_NO_BATTERY
  } cup_chg_fault_t;
  typedef enum logic [2:0] {
    BF_NORMAL, BF_BUS_OVP, BF_OVERLOAD, BF_BAT_LOW, BF_BAT_OVP,
    BF_THERMAL, BF_TIMER, BF_UNUSED
  } cup_boost_fault_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WR, ST_WACK,
    ST_RD, ST_RACK
  } cup_i2c_state_t;
  typedef struct packed {
    cup_chg_state_t charge_state;
    logic [2:0]     fault;
    logic           boost_active;
    logic           bus_power_present;
    logic           wall_input_present;
    logic           power_management_active;
  } cup_status_t;
  typedef struct packed {
    logic [1:0] input_limit;
    logic [1:0] weak_battery_threshold;
    logic       end_cut_enable;
    logic       charger_off;
    logic       input_high_impedance;
    logic       operation_select;
    logic [5:0] regulation_voltage_code;
    logic       host_pin_polarity;
    logic       host_pin_enable;
    logic [3:0] fast_current_code;
    logic [2:0] end_current_code;
    logic       low_current_override;
    logic [2:0] special_supply_voltage_code;
  } cup_ctrl_t;
endpackage

// ### tb/cup_host_model.sv
// serial bus master model standing in for the host processor
`timescale 1ns/1ps
module cup_host_model #(
  parameter logic [6:0] ADDR = 7'h6B
) (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // sda_o high means released; the wire then sits at its pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // quarter bus period is two ref clocks, so the bus runs at 320 ns
  // wait out the slave's acknowledge before letting go of sda, or a
  // repeated start would look like a stop to the slave
  task automatic start();
    tick(2);
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // data moves only while scl is low; msb first, ninth bit is acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_o <= tx[i];
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      rx[i] = sda_i;
      tick(2);
      scl_o <= 1'b0;
    end
    q   = rx[8:1];
    ack = rx[0];
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d,
                        output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a[0]);
    xfer(ptr, 1'b1, q, a[1]);
    xfer(d, 1'b1, q, a[2]);
    stop();
    ok = (a == 3'h0);
  endtask
  // last byte is refused with a nack so the device lets go of sda
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] q,
                        output logic ok);
    logic [2:0] a;
    logic       n;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a[0]);
    xfer(ptr, 1'b1, q, a[1]);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, a[2]);
    xfer(8'hFF, 1'b1, q, n);
    stop();
    ok = (a == 3'h0);
  endtask
endmodule

// ### tb/cup_bank_tb.sv
// self-checking testbench of the charging core register bank
`timescale 1ns/1ps
module cup_bank_tb;
  import cup_pkg::*;
  // identity values are arbitrary
  localparam logic [2:0] MK = 3'h6;
  localparam logic [1:0] PC = 2'h1;
  localparam logic [2:0] RV = 3'h5;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        scl;
  logic        host_sda;
  logic        sda_o;
  logic        sda_oe_n_o;
  logic        pin       = 1'b0;
  cup_status_t status    = '0;
  logic [2:0]  slim      = 3'h7;
  cup_ctrl_t   ctrl;
  logic        kick;
  logic        crst;
  logic        hma;
  logic        stat_o;
  logic        stat_oe_n;
  logic [2:0]  effw;
  logic        effl;
  wire         sda_w = host_sda & (sda_oe_n_o | sda_o);
  int          n_errors = 0;
  int          compares = 0;
  int          n_kick   = 0;
  int          n_crst   = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  cup_host_model host (
    .ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  cup_bank #(.MAKER_CODE(MK), .PART_CODE(PC), .REV_CODE(RV)) uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .host_mode_request_pin_i(pin), .status_i(status),
    .safety_fast_limit_i(slim), .ctrl_o(ctrl),
    .safety_timer_kick_o(kick), .core_reset_o(crst),
    .host_mode_active_o(hma), .stat_o(stat_o), .stat_oe_n_o(stat_oe_n),
    .eff_fast_weight_o(effw), .eff_low_current_o(effl));
  // pulse widths are counted in cycles, so a stretched pulse shows up
  always @(posedge ref_clk_i) begin
    if (kick === 1'b1) n_kick++;
    if (crst === 1'b1) n_crst++;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.wr_reg(p, d, ok);
    chk1(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] q;
    host.rd_reg(p, q, ok);
    chk1(ok, 1'b1);
    chk8(q, e);
  endtask
  task automatic t_defaults();
    rd(8'h00, 8'h40);
    rd(8'h01, 8'h30);
    rd(8'h02, 8'h0A);
    rd(8'h04, 8'h01);
    rd(8'h05, 8'h24);
    chk1(effl, 1'b1);
  endtask
  // every charge state and fault code, and eight of the sixteen flag patterns, seen through regs 0 and 5
  task automatic t_status();
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      @(posedge ref_clk_i);
      status <= '{cup_chg_state_t'(k[1:0]), k, k[0], k[1], k[2], ~k[0]};
      pin    <= k[1];
      rd(8'h00, {k[1], 1'b1, k[1:0], k[0], k});
      rd(8'h05, {1'b0, k[1], 1'b1, ~k[0], k[2], 3'h4});
      chk1(stat_oe_n, k[1:0] != 2'h1);
      chk1(hma, 1'b0);
    end
  endtask
  task automatic t_write();
    wr(8'h01, 8'hCF);
    chk8(ctrl[26:19], 8'hCF);
    rd(8'h01, 8'hCF);
    wr(8'h02, 8'h2F);
    chk8({2'h0, ctrl.regulation_voltage_code}, 8'h0B);
    @(posedge ref_clk_i);
    pin <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk1(hma, 1'b1);
    pin <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    chk1(hma, 1'b0);
    wr(8'h02, 8'h2D);
    chk1(hma, 1'b1);
    wr(8'h05, 8'h83);
    rd(8'h05, 8'h4B);
    chk1(effl, 1'b0);
  endtask
  task automatic t_kick();
    @(posedge ref_clk_i);
    status.charge_state <= CHG_CHARGING;
    n_kick = 0;
    wr(8'h00, 8'hC0);
    chk8(n_kick[7:0], 8'h01);
    rd(8'h00, 8'h5F);
    chk1(stat_oe_n, 1'b0);
    chk1(stat_o, 1'b0);
    wr(8'h00, 8'h00);
    chk1(stat_oe_n, 1'b1);
    chk8(n_kick[7:0], 8'h01);
    wr(8'h00, 8'h40);
  endtask
  task automatic t_cur();
    wr(8'h04, 8'h7E);
    rd(8'h04, 8'h7E);
    chk8({1'b0, ctrl.fast_current_code, ctrl.end_current_code},
         8'h7E);
    @(posedge ref_clk_i);
    slim <= 3'h3;
    repeat (4) @(posedge ref_clk_i);
    chk8({5'h0, effw}, 8'h03);
    slim <= 3'h7;
    wr(8'h04, 8'h5E);
    chk8({5'h0, effw}, 8'h05);
    n_crst = 0;
    wr(8'h04, 8'hAE);
    chk8(n_crst[7:0], 8'h01);
    rd(8'h01, 8'h30);
    rd(8'h04, 8'h01);
    chk1(ctrl.low_current_override, 1'b1);
  endtask
  task automatic t_id();
    logic [7:0] q;
    logic       a;
    rd(8'h03, {MK, PC, RV});
    wr(8'h03, 8'h00);
    rd(8'h03, {MK, PC, RV});
    rd(8'h07, 8'h00);
    host.start();
    host.xfer({7'h6A, 1'b0}, 1'b1, q, a);
    host.stop();
    chk1(a, 1'b1);
    rd(8'h01, 8'h30);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_defaults();
    t_status();
    t_write();
    t_kick();
    t_cur();
    t_id();
    tally_and_finish();
  end
endmodule
